// File: hw/spi_fifo_data_status.sv
module spi_fifo_data_status (
    input  wire logic        clk_sys,   // System clock, 25 MHz.
    input  wire logic        rst_b,     // Synchronous reset, active low.
    input  wire logic [7:0]  reg_addr,  // Register byte address.
    input  wire logic [31:0] reg_wdata, // Register write data.
    input  wire logic        reg_wr,    // Write strobe, one cycle.
    input  wire logic        reg_rd,    // Read strobe, one cycle.
    output logic      [31:0] reg_rdata, // Read data, valid the cycle after reg_rd.
    input  wire logic        sclk,      // Serial clock from the link master.
    input  wire logic        ss_b,      // Slave select, active low.
    input  wire logic        mosi,      // Serial data in.
    output logic             miso_out,  // Serial data out.
    output logic             miso_oe,   // Drive enable for serial data out.
    output logic             irq        // Level interrupt.
);

    // ------------------------------------------------------------------
    // Declarations.
    // ------------------------------------------------------------------
    spi_fifo_pkg::frame_state_t state_r;

    logic [4:0]  frame_size_r;
    logic        rx_input_delay_sel;
    logic [2:0]  irq_mask_r;
    logic [2:0]  irq_status_r;
    logic [2:0]  irq_event;

    logic        sclk_s1;
    logic        sclk_s2;
    logic        sclk_s3;
    logic        ss_s1;
    logic        ss_s2;
    logic        mosi_s1;
    logic        mosi_s2;
    logic [spi_fifo_pkg::RX_DELAY_CYCLES-1:0] mosi_dly_r;
    logic        rx_bit;
    logic        sclk_rise;
    logic        sclk_fall;
    logic        ss_active;

    logic [31:0] tx_sh_r;
    logic [31:0] rx_sh_r;
    logic [4:0]  bit_cnt_r;
    logic        reload_pend_r;
    logic        load_tx;
    logic        last_bit;
    logic [31:0] frame_mask;
    logic [31:0] rx_word;

    logic        wr_data_port;
    logic        rd_data_port;
    logic [31:0] tx_head;
    logic [31:0] rx_head;
    logic        tx_empty;
    logic        tx_full;
    logic        rx_empty;
    logic        rx_full;
    logic        tx_pop;
    logic        rx_push;
    logic        shift_active_flag;
    logic [4:0]  status_bits;

    // ------------------------------------------------------------------
    // Link input synchronisers.
    // ------------------------------------------------------------------

    // Every link pin passes two flops; the third sclk flop feeds edge detection only.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            sclk_s1 <= 1'b0;
            sclk_s2 <= 1'b0;
            sclk_s3 <= 1'b0;
            ss_s1   <= 1'b1;
            ss_s2   <= 1'b1;
            mosi_s1 <= 1'b0;
            mosi_s2 <= 1'b0;
        end else begin
            sclk_s1 <= sclk;
            sclk_s2 <= sclk_s1;
            sclk_s3 <= sclk_s2;
            ss_s1   <= ss_b;
            ss_s2   <= ss_s1;
            mosi_s1 <= mosi;
            mosi_s2 <= mosi_s1;
        end
    end

    assign sclk_rise = sclk_s2 & ~sclk_s3;
    assign sclk_fall = ~sclk_s2 & sclk_s3;
    assign ss_active = ~ss_s2;

    // Optional input delay line; it helps when the partner's data changes soon after the rise, and late data is taken one bit old.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            mosi_dly_r <= '0;
        end else begin
            mosi_dly_r <= {mosi_dly_r[spi_fifo_pkg::RX_DELAY_CYCLES-2:0], mosi_s2};
        end
    end

    // The sample point stays on the sclk edge, so a delayed bit is two cycles older.
    assign rx_bit = rx_input_delay_sel
                  ? mosi_dly_r[spi_fifo_pkg::RX_DELAY_CYCLES-1]
                  : mosi_s2;

    // ------------------------------------------------------------------
    // Register port decode.
    // ------------------------------------------------------------------
    assign wr_data_port = reg_wr & (reg_addr == spi_fifo_pkg::OFS_DATA_PORT);
    assign rd_data_port = reg_rd & (reg_addr == spi_fifo_pkg::OFS_DATA_PORT);

    // Configuration registers written by software.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            frame_size_r       <= spi_fifo_pkg::FRAME_SIZE_RST;
            rx_input_delay_sel <= spi_fifo_pkg::RX_DELAY_SEL_RST;
            irq_mask_r         <= spi_fifo_pkg::IRQ_MASK_RST;
        end else if (reg_wr) begin
            case (reg_addr)
                spi_fifo_pkg::OFS_FRAME_CFG: begin
                    frame_size_r <= reg_wdata[spi_fifo_pkg::FRAME_SIZE_W-1:0];
                end
                spi_fifo_pkg::OFS_LINK_CTRL: begin
                    rx_input_delay_sel <= reg_wdata[spi_fifo_pkg::BIT_RX_DELAY_SEL];
                end
                spi_fifo_pkg::OFS_IRQ_MASK: begin
                    irq_mask_r <= reg_wdata[spi_fifo_pkg::IRQ_W-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Transmit and receive queues.
    // ------------------------------------------------------------------

    // A write to the data port queues the word; a write into a full queue is lost.
    word_queue u_tx_queue (
        .clk_sys   (clk_sys),
        .rst_b     (rst_b),
        .push      (wr_data_port),
        .push_data (reg_wdata),
        .pop       (tx_pop),
        .head_data (tx_head),
        .empty     (tx_empty),
        .full      (tx_full)
    );

    // A read of the data port removes the oldest received word.
    word_queue u_rx_queue (
        .clk_sys   (clk_sys),
        .rst_b     (rst_b),
        .push      (rx_push),
        .push_data (rx_word),
        .pop       (rd_data_port),
        .head_data (rx_head),
        .empty     (rx_empty),
        .full      (rx_full)
    );

    // ------------------------------------------------------------------
    // Frame engine.
    // ------------------------------------------------------------------

    // A new transmit word is taken at select and after each completed frame.
    assign load_tx  = ss_active & ((state_r == spi_fifo_pkg::FR_IDLE) |
                      ((state_r == spi_fifo_pkg::FR_SHIFT) & sclk_fall & reload_pend_r));
    assign tx_pop   = load_tx & ~tx_empty;
    assign last_bit = ss_active & (state_r == spi_fifo_pkg::FR_SHIFT) & sclk_rise &
                      (bit_cnt_r == frame_size_r);

    // Frame mask keeps bits 0 to frame_size; frame_size holds the size minus one.
    assign frame_mask = 32'hffffffff >> (5'd31 - frame_size_r);
    assign rx_word    = {rx_sh_r[30:0], rx_bit} & frame_mask;
    assign rx_push    = last_bit;

    // Deselect in mid-frame drops the partial frame and returns to idle.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            state_r <= spi_fifo_pkg::FR_IDLE;
        end else begin
            case (state_r)
                spi_fifo_pkg::FR_IDLE: begin
                    if (ss_active) begin
                        state_r <= spi_fifo_pkg::FR_SHIFT;
                    end
                end
                spi_fifo_pkg::FR_SHIFT: begin
                    if (!ss_active) begin
                        state_r <= spi_fifo_pkg::FR_IDLE;
                    end
                end
                default: begin
                    state_r <= spi_fifo_pkg::FR_IDLE;
                end
            endcase
        end
    end

    // Bit counter and the flag that defers the reload to the next falling edge.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            bit_cnt_r     <= '0;
            reload_pend_r <= 1'b0;
        end else if (state_r != spi_fifo_pkg::FR_SHIFT || !ss_active) begin
            bit_cnt_r     <= '0;
            reload_pend_r <= 1'b0;
        end else begin
            if (last_bit) begin
                bit_cnt_r     <= '0;
                reload_pend_r <= 1'b1;
            end else if (sclk_rise) begin
                bit_cnt_r <= bit_cnt_r + 1'b1;
            end
            if (load_tx) begin
                reload_pend_r <= 1'b0;
            end
        end
    end

    // The word is left-aligned so bits above the frame size are never sent.
    // An empty queue sends zeros and raises an underrun.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            tx_sh_r <= '0;
        end else if (load_tx) begin
            tx_sh_r <= tx_empty ? 32'h0 : (tx_head << (5'd31 - frame_size_r));
        end else if (ss_active && sclk_fall && state_r == spi_fifo_pkg::FR_SHIFT) begin
            tx_sh_r <= {tx_sh_r[30:0], 1'b0};
        end
    end

    // Receive shifts in at the low end; mask on push clears the bits above the frame.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            rx_sh_r <= '0;
        end else if (ss_active && sclk_rise && state_r == spi_fifo_pkg::FR_SHIFT) begin
            rx_sh_r <= {rx_sh_r[30:0], rx_bit};
        end
    end

    // Output data comes from a flop; the pin is driven only while selected.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            miso_out <= 1'b0;
            miso_oe  <= 1'b0;
        end else begin
            miso_out <= tx_sh_r[31];
            miso_oe  <= ss_active;
        end
    end

    // ------------------------------------------------------------------
    // Status and interrupts.
    // ------------------------------------------------------------------
    assign shift_active_flag = (state_r == spi_fifo_pkg::FR_SHIFT) | ~tx_empty;

    assign status_bits[spi_fifo_pkg::BIT_TX_EMPTY]     = tx_empty;
    assign status_bits[spi_fifo_pkg::BIT_TX_ROOM]      = ~tx_full;
    assign status_bits[spi_fifo_pkg::BIT_RX_ENTRY]     = ~rx_empty;
    assign status_bits[spi_fifo_pkg::BIT_RX_FULL]      = rx_full;
    assign status_bits[spi_fifo_pkg::BIT_SHIFT_ACTIVE] = shift_active_flag;

    assign irq_event[spi_fifo_pkg::IRQ_RX_FRAME]    = rx_push & ~rx_full;
    assign irq_event[spi_fifo_pkg::IRQ_RX_OVERRUN]  = rx_push & rx_full;
    assign irq_event[spi_fifo_pkg::IRQ_TX_UNDERRUN] = load_tx & tx_empty;

    // Write one to clear; an event in the clearing cycle still sets the bit.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            irq_status_r <= '0;
        end else if (reg_wr && reg_addr == spi_fifo_pkg::OFS_IRQ_STATUS) begin
            irq_status_r <= (irq_status_r & ~reg_wdata[spi_fifo_pkg::IRQ_W-1:0]) | irq_event;
        end else begin
            irq_status_r <= irq_status_r | irq_event;
        end
    end

    assign irq = |(irq_status_r & irq_mask_r);

    // ------------------------------------------------------------------
    // Read data, one cycle after the strobe; unmapped addresses read zero.
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            reg_rdata <= spi_fifo_pkg::DATA_PORT_RST;
        end else if (reg_rd) begin
            case (reg_addr)
                spi_fifo_pkg::OFS_FRAME_CFG: begin
                    reg_rdata <= {27'h0, frame_size_r};
                end
                spi_fifo_pkg::OFS_LINK_CTRL: begin
                    reg_rdata <= 32'(rx_input_delay_sel) << spi_fifo_pkg::BIT_RX_DELAY_SEL;
                end
                spi_fifo_pkg::OFS_DATA_PORT: begin
                    reg_rdata <= rx_empty ? 32'h0 : rx_head;
                end
                spi_fifo_pkg::OFS_STATUS: begin
                    reg_rdata <= {27'h0, status_bits};
                end
                spi_fifo_pkg::OFS_IRQ_STATUS: begin
                    reg_rdata <= {29'h0, irq_status_r};
                end
                spi_fifo_pkg::OFS_IRQ_MASK: begin
                    reg_rdata <= {29'h0, irq_mask_r};
                end
                default: begin
                    reg_rdata <= 32'h0;
                end
            endcase
        end else begin
            reg_rdata <= 32'h0;
        end
    end

endmodule // spi_fifo_data_status

// File: hw/word_queue.sv
module word_queue (
    input  wire logic                       clk_sys,    // System clock.
    input  wire logic                       rst_b,      // Synchronous reset, active low.
    input  wire logic                       push,       // Write one word.
    input  wire logic [spi_fifo_pkg::DATA_W-1:0] push_data, // Word to write.
    input  wire logic                       pop,        // Remove the oldest word.
    output logic [spi_fifo_pkg::DATA_W-1:0] head_data,  // Oldest word.
    output logic                            empty,      // No entries held.
    output logic                            full        // No room left.
);

    logic [spi_fifo_pkg::DATA_W-1:0]   mem [spi_fifo_pkg::QUEUE_DEPTH];
    logic [spi_fifo_pkg::QUEUE_AW-1:0] wr_ptr_r;
    logic [spi_fifo_pkg::QUEUE_AW-1:0] rd_ptr_r;
    logic [spi_fifo_pkg::QUEUE_AW:0]   count_r;
    logic [spi_fifo_pkg::QUEUE_AW:0]   count_nxt;
    logic                              do_push;
    logic                              do_pop;

    // A push into a full queue or a pop from an empty one is dropped.
    assign do_push   = push & ~full;
    assign do_pop    = pop & ~empty;
    assign head_data = mem[rd_ptr_r];

    // Storage writes; no reset so the array maps onto plain memory.
    always_ff @(posedge clk_sys) begin
        if (do_push) begin
            mem[wr_ptr_r] <= push_data;
        end
    end

    // Pointers advance by one and wrap at the power-of-two depth.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else begin
            if (do_push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (do_pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
        end
    end

    always_comb begin
        count_nxt = count_r;
        if (do_push && !do_pop) begin
            count_nxt = count_r + 1'b1;
        end else if (do_pop && !do_push) begin
            count_nxt = count_r - 1'b1;
        end
    end

    // Flags are registered from the next count, so they settle the cycle after a change.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            count_r <= '0;
            empty   <= 1'b1;
            full    <= 1'b0;
        end else begin
            count_r <= count_nxt;
            empty   <= (count_nxt == '0);
            full    <= (count_nxt == (spi_fifo_pkg::QUEUE_AW+1)'(spi_fifo_pkg::QUEUE_DEPTH));
        end
    end

endmodule // word_queue

// File: shared/spi_fifo_pkg.sv
package spi_fifo_pkg;

    // ------------------------------------------------------------------
    // Register map (byte offsets on the plain register port).
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_FRAME_CFG  = 8'h00;
    localparam logic [7:0] OFS_LINK_CTRL  = 8'h04;
    localparam logic [7:0] OFS_DATA_PORT  = 8'h08;
    localparam logic [7:0] OFS_STATUS     = 8'h0c;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h28;
    localparam logic [7:0] OFS_IRQ_MASK   = 8'h2c;

    // ------------------------------------------------------------------
    // Field positions and widths.
    // ------------------------------------------------------------------
    localparam int          FRAME_SIZE_W       = 5;
    localparam int          BIT_RX_DELAY_SEL   = 21;
    localparam int          BIT_TX_EMPTY       = 0;
    localparam int          BIT_TX_ROOM        = 1;
    localparam int          BIT_RX_ENTRY       = 2;
    localparam int          BIT_RX_FULL        = 3;
    localparam int          BIT_SHIFT_ACTIVE   = 4;
    localparam int          STATUS_W           = 5;
    localparam int          IRQ_W              = 3;
    localparam int          IRQ_RX_FRAME       = 0;
    localparam int          IRQ_RX_OVERRUN     = 1;
    localparam int          IRQ_TX_UNDERRUN    = 2;

    // ------------------------------------------------------------------
    // Reset values, sizes and cycle counts.
    // ------------------------------------------------------------------
    localparam logic [4:0]  FRAME_SIZE_RST     = 5'h07;
    localparam logic        RX_DELAY_SEL_RST   = 1'h0;
    localparam logic [2:0]  IRQ_MASK_RST       = 3'h0;
    localparam logic [31:0] DATA_PORT_RST      = 32'h0;
    localparam int          DATA_W             = 32;
    localparam int          QUEUE_DEPTH        = 8;
    localparam int          QUEUE_AW           = 3;
    localparam int          RX_DELAY_CYCLES    = 2;

    // Frame engine states, one-hot.
    typedef enum logic [1:0] {
        FR_IDLE  = 2'b01,
        FR_SHIFT = 2'b10
    } frame_state_t;

endpackage

// File: testbench/spi_fifo_checker_sva.sv
module spi_fifo_checker (
    input wire logic        clk_sys,   // System clock.
    input wire logic        rst_b,     // Synchronous reset, active low.
    input wire logic [7:0]  reg_addr,  // Register byte address.
    input wire logic [31:0] reg_wdata, // Register write data.
    input wire logic        reg_wr,    // Write strobe.
    input wire logic        reg_rd,    // Read strobe.
    input wire logic [31:0] reg_rdata, // Read data.
    input wire logic        ss_b,      // Link select, active low.
    input wire logic        miso_oe,   // Serial output enable.
    input wire logic        irq        // Level interrupt.
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Offsets watched by the properties below.
    // ------------------------------------------------------------
    localparam logic [7:0] stat_ofs = spi_fifo_pkg::OFS_STATUS;
    localparam logic [7:0] data_ofs = spi_fifo_pkg::OFS_DATA_PORT;
    localparam logic [7:0] mask_ofs = spi_fifo_pkg::OFS_IRQ_MASK;

    // All properties live in the one clock domain and are off during reset.
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    // Read data must only stand in the answer cycle, so software never sees stale words.
    rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0)
        else $error("read data not zero outside an answer cycle");
    resv_zero_a: assert property (reg_rd && reg_addr == stat_ofs |=> reg_rdata[31:5] == 27'h0)
        else $error("reserved status bits not zero");
    tx_flags_a: assert property (reg_rd && reg_addr == stat_ofs |=> !(reg_rdata[0] && !reg_rdata[1]))
        else $error("transmit queue empty yet reported full");
    rx_flags_a: assert property (reg_rd && reg_addr == stat_ofs |=> !(reg_rdata[3] && !reg_rdata[2]))
        else $error("receive queue full yet reported empty");
    busy_pending_a: assert property (reg_rd && reg_addr == stat_ofs |=> reg_rdata[0] || reg_rdata[4])
        else $error("pending transmit word without busy flag");
    // The link must be quiet for a while, otherwise a frame start could pop the word again.
    push_seen_a: assert property (ss_b [*4] ##0 reg_wr && reg_addr == data_ofs ##1
        reg_rd && reg_addr == stat_ofs && ss_b |=> !reg_rdata[0] && reg_rdata[4])
        else $error("pushed word not shown in status on the next read");
    mask_quiet_a: assert property (reg_wr && reg_addr == mask_ofs && reg_wdata[2:0] == 3'h0 |=> !irq)
        else $error("interrupt high with every source masked");
    oe_idle_a: assert property (ss_b [*5] |-> !miso_oe)
        else $error("serial output driven while not selected");
    reset_quiet_a: assert property ($rose(rst_b) |-> reg_rdata == 32'h0 && !miso_oe && !irq)
        else $error("outputs not quiet after reset");
endmodule // spi_fifo_checker

// File: testbench/spi_fifo_data_status_bench.sv
module spi_fifo_data_status_bench;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Signals, notes and counters.
    // ------------------------------------------------------------
    logic        clk_sys;
    logic        rst_b;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_rdata;
    logic        sclk, ss_b, mosi, miso_out, miso_oe, irq;
    logic        rd_d = 1'b0;
    logic [31:0] exp_q[$];
    logic [7:0]  miso_q[$];
    logic [7:0]  rxq[$];
    int          n_errors = 0;
    int          n_tests = 0;

    spi_fifo_data_status dut (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .sclk(sclk), .ss_b(ss_b), .mosi(mosi), .miso_out(miso_out), .miso_oe(miso_oe),
        .irq(irq));
    spi_master_model u_master (.sclk(sclk), .ss_b(ss_b), .mosi(mosi),
        .miso_out(miso_out), .miso_oe(miso_oe));

    // 25 MHz system clock.
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    // ------------------------------------------------------------
    // Comparison, verdict and bus tasks.
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("Checks %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Each task sets both strobes once, so back-to-back calls never double-assign.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        reg_rd <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        reg_addr <= a;
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk_sys);
    endtask

    task automatic idle();
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        @(posedge clk_sys);
    endtask

    // Read answers are taken off the note queue in the middle of the answer cycle.
    always @(posedge clk_sys) rd_d <= reg_rd;
    always @(negedge clk_sys) begin
        if (rd_d) chk(reg_rdata, exp_q.pop_front());
    end
    // Serial bytes are compared as each frame completes.
    always @(u_master.got_ev) chk({24'h0, u_master.got_byte}, {24'h0, miso_q.pop_front()});

    // A hang far beyond the few frames sent ends the run as a mismatch.
    initial begin
        #400_000;
        n_errors++;
        test_done();
    end

    // ------------------------------------------------------------
    // Main sequence.
    // ------------------------------------------------------------
    initial begin
        logic [31:0] w;
        logic [7:0]  b;
        void'($urandom(32'h8278));
        rst_b = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (8) @(posedge clk_sys);
        rst_b <= 1'b1;
        @(posedge clk_sys);
        rd(spi_fifo_pkg::OFS_STATUS, 32'h3);
        rd(spi_fifo_pkg::OFS_DATA_PORT, 32'h0);
        rd(8'h10, 32'h0);
        wr(spi_fifo_pkg::OFS_STATUS, 32'hffff_ffff);
        rd(spi_fifo_pkg::OFS_STATUS, 32'h3);
        // Full-width words test that only the low frame bits go out; the ninth is refused.
        for (int i = 0; i < 9; i++) begin
            w = $urandom;
            wr(spi_fifo_pkg::OFS_DATA_PORT, w);
            if (i < 8) miso_q.push_back(w[7:0]);
            if (i == 0) rd(spi_fifo_pkg::OFS_STATUS, 32'h12);
        end
        rd(spi_fifo_pkg::OFS_STATUS, 32'h10);
        idle();
        for (int i = 0; i < 8; i++) begin
            b = 8'($urandom);
            u_master.tx_q.push_back(b);
            rxq.push_back(b);
        end
        // Data arriving 20 ns before each rise must still land on its own bit.
        u_master.burst(0, 20);
        repeat (8) @(posedge clk_sys);
        rd(spi_fifo_pkg::OFS_STATUS, 32'h0f);
        idle();
        chk({31'h0, irq}, 32'h0);
        wr(spi_fifo_pkg::OFS_IRQ_MASK, 32'h1);
        idle();
        chk({31'h0, irq}, 32'h1);
        wr(spi_fifo_pkg::OFS_IRQ_STATUS, 32'h7);
        idle();
        chk({31'h0, irq}, 32'h0);
        // Back-to-back pops; the status read right after the first pop must see it.
        for (int i = 0; i < 8; i++) begin
            rd(spi_fifo_pkg::OFS_DATA_PORT, {24'h0, rxq.pop_front()});
            if (i == 0) rd(spi_fifo_pkg::OFS_STATUS, 32'h07);
        end
        rd(spi_fifo_pkg::OFS_STATUS, 32'h3);
        // Delayed input path with a slow link; late data is then taken one bit old.
        wr(spi_fifo_pkg::OFS_LINK_CTRL, 32'h1 << spi_fifo_pkg::BIT_RX_DELAY_SEL);
        w = $urandom & 32'hff;
        wr(spi_fifo_pkg::OFS_DATA_PORT, w);
        miso_q.push_back(w[7:0]);
        b = 8'($urandom);
        u_master.tx_q.push_back(b);
        idle();
        u_master.burst(120, 20);
        repeat (8) @(posedge clk_sys);
        // Two cycles of delay sample the line before the late change, so the
        // frame arrives as the idle low bit followed by the top seven bits.
        rd(spi_fifo_pkg::OFS_DATA_PORT, {25'h0, b[7:1]});
        wr(spi_fifo_pkg::OFS_IRQ_MASK, 32'h0);
        idle();
        idle();
        test_done();
    end
endmodule // spi_fifo_data_status_bench

bind spi_fifo_data_status spi_fifo_checker u_chk (.clk_sys(clk_sys), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ss_b(ss_b), .miso_oe(miso_oe), .irq(irq));

// File: testbench/spi_master_model.sv
module spi_master_model (
    output logic      sclk,     // Serial clock, idles low.
    output logic      ss_b,     // Select, active low.
    output logic      mosi,     // Serial data to the block.
    input wire logic  miso_out, // Serial data from the block.
    input wire logic  miso_oe   // Block drives its serial output.
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] tx_q[$];  // Bytes to send, oldest first.
    logic [7:0] got_byte; // Last byte captured from the block.
    event       got_ev;   // Fires once per captured byte.

    // Idle lines at time zero; the clock stands still outside frames.
    initial begin
        sclk = 1'b0;
        ss_b = 1'b1;
        mosi = 1'b0;
        got_byte = 8'h00;
    end

    // Mode 0 burst: all queued bytes back to back under one select.
    // A nonzero late puts each bit on the line only that many ns before the rise,
    // and the line idles low at select; this is how a slow partner looks.
    // The block output is taken just before each fall, where it is surely settled.
    task automatic burst(input int gap, input int late);
        logic [7:0] b;
        logic [7:0] r;
        // Start off the system clock edge so no link pin changes in a sampling step.
        #7;
        ss_b = 1'b0;
        if (late > 0) mosi = 1'b0;
        while (tx_q.size() > 0) begin
            b = tx_q.pop_front();
            for (int i = 7; i >= 0; i--) begin
                if (late == 0) mosi = b[i];
                #(160 + gap - late) mosi = b[i];
                #(late) sclk = 1'b1;
                #160 r[i] = miso_oe ? miso_out : 1'bx;
                sclk = 1'b0;
            end
            got_byte = r;
            -> got_ev;
        end
        #160 ss_b = 1'b1;
        mosi = ~mosi; // Released line shows no stale value.
    endtask
endmodule // spi_master_model
